// >>> logic/cvd_pkg.sv
// Register map, field positions, reset values and sequencer states
// Assumes an 8-bit register port and one ref_clk domain at 10 MHz
package cvd_pkg;
    // Register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_COM  = 4'h1;
    localparam logic [3:0] OFS_CON3 = 4'h2;
    localparam logic [3:0] OFS_STAT = 4'h3;
    localparam logic [3:0] OFS_PRE  = 4'h4;
    localparam logic [3:0] OFS_ACQ  = 4'h5;
    localparam logic [3:0] OFS_GRD  = 4'h6;
    localparam logic [3:0] OFS_CAP  = 4'h7;
    localparam logic [3:0] OFS_R0L  = 4'h8;
    localparam logic [3:0] OFS_R0H  = 4'h9;
    localparam logic [3:0] OFS_R1L  = 4'hA;
    localparam logic [3:0] OFS_R1H  = 4'hB;
    localparam logic [3:0] OFS_CH   = 4'hC;
    localparam logic [3:0] OFS_FLAG = 4'hD;
    // Field positions
    localparam int BIT_ON   = 0;
    localparam int BIT_GO   = 1;
    localparam int CHS_LSB  = 2;
    localparam int BIT_EPOL = 0;
    localparam int BIT_IPOL = 1;
    localparam int BIT_INV  = 6;
    localparam int BIT_DBL  = 7;
    localparam int BIT_GPOL = 0;
    localparam int BIT_GB   = 6;
    localparam int BIT_GA   = 7;
    // Reset values and counts
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [6:0] CNT_RST  = 7'h00;
    localparam logic [9:0] RES_RST  = 10'h000;
    localparam logic [3:0] SAR_MSB  = 4'h9;
    localparam logic [1:0] GAP_LAST = 2'h1;  // Two clocks between samples
    // Sequencer stages
    typedef enum logic [2:0] {
        CVD_IDLE,
        CVD_PRE,
        CVD_ACQ,
        CVD_CONV,
        CVD_GAP
    } cvd_state_e;
endpackage

// >>> logic/cvd_sar.sv
// Ten-bit successive approximation control, one bit per conversion tick
// Assumes cmp_in is the comparator verdict for the current trial word
`timescale 1ns/1ps
`default_nettype none
module cvd_sar
    import cvd_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic       tick,
    input  wire logic       cmp_in,
    // Results
    output logic [9:0]      trial,
    output logic [9:0]      result,
    output logic            res_valid,
    output logic            done
);
    logic [9:0] trial_r;
    logic [9:0] res_r;
    logic [3:0] idx_r;
    logic       busy_r;
    logic       valid_r;
    logic       done_r;
    logic       last_bit;

    // Undecided bits copy the last decided one
    function automatic logic [9:0] fill_low(input logic [9:0] v, input logic [3:0] idx);
        logic [9:0] o;
        logic       last;
        o = v;
        last = (idx == SAR_MSB) ? 1'b0 : v[idx + 4'h1];
        for (int i = 0; i < 10; i++)
            if (i <= int'(idx))
                o[i] = last;
        return o;
    endfunction

    assign last_bit = busy_r && tick && (idx_r == 4'h0);

    // Bit-by-bit trial sequence
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            busy_r  <= 1'b0;
            trial_r <= RES_RST;
            idx_r   <= 4'h0;
        end else if (abort) begin
            busy_r <= 1'b0;
        end else if (start) begin
            busy_r  <= 1'b1;
            idx_r   <= SAR_MSB;
            trial_r <= 10'h200;
        end else if (busy_r && tick) begin
            trial_r[idx_r] <= cmp_in;
            if (idx_r != 4'h0) begin
                trial_r[idx_r - 4'h1] <= 1'b1;
                idx_r <= idx_r - 4'h1;
            end else begin
                busy_r <= 1'b0;
            end
        end
    end

    // Result capture on completion or abort
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            res_r   <= RES_RST;
            valid_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            if (busy_r && abort)
                res_r <= fill_low(trial_r, idx_r);
            else if (last_bit)
                res_r <= {trial_r[9:1], cmp_in};
            valid_r <= busy_r && (abort || (tick && idx_r == 4'h0));
            done_r  <= last_bit && !abort;
        end
    end

    assign trial     = trial_r;
    assign result    = res_r;
    assign res_valid = valid_r;
    assign done      = done_r;
endmodule
`default_nettype wire

// >>> logic/cvd_seq.sv
// Capacitive divider sequencer: registers, stage control, pin and guard drive
// Assumes synchronous inputs on ref_clk and a one-cycle cycle_tick time base
`timescale 1ns/1ps
`default_nettype none
module cvd_seq
    import cvd_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Time base and triggers
    input  wire logic       cycle_tick,
    input  wire logic       trig_in,
    input  wire logic       cmp_in,
    // Converter side
    output logic [9:0]      sar_trial,
    output logic            conv_active,
    output logic            conversion_done_flag,
    // Hold capacitor
    output logic            hold_bias_en,
    output logic            hold_bias_high,
    output logic [3:0]      extra_cap_sel,
    // Channel mux and pin override
    output logic            mux_connect,
    output logic [4:0]      mux_channel,
    output logic [7:0]      sec_mux_connect,
    output logic [7:0]      sec_force_input,
    output logic            pin_drive_en,
    output logic            pin_drive_high,
    output logic [7:0]      sec_drive_en,
    // Guard ring
    output logic            guard_a,
    output logic            guard_a_oe,
    output logic            guard_b,
    output logic            guard_b_oe
);
    cvd_state_e st_r;
    cvd_state_e st_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] con3_r;
    logic [6:0] pre_r;
    logic [6:0] acq_r;
    logic [7:0] grd_r;
    logic [3:0] cap_r;
    logic [7:0] ch_r;
    logic [9:0] res0_r;
    logic [9:0] res1_r;
    logic [7:0] rdata_r;
    logic       go_r;
    logic       go_all_r;
    logic       flag_r;
    logic       sample_r;
    logic       guard_lvl_r;
    logic [1:0] gap_r;
    logic       on;
    logic       inv;
    logic       wr_ctrl;
    logic       wr_com;
    logic       start_evt;
    logic       sw_clr;
    logic       abort;
    logic       tmr_exp;
    logic       tmr_load;
    logic       sar_done;
    logic       sar_valid;
    logic [9:0] sar_res;
    logic       seq_end;

    // First stage of a sample, used at start and after the gap
    function automatic cvd_state_e first_stage(input logic [6:0] pre, input logic [6:0] acq);
        if (pre != 7'h00)
            return CVD_PRE;
        else if (acq != 7'h00)
            return CVD_ACQ;
        else
            return CVD_CONV;
    endfunction

    // Decoded controls
    assign on      = ctrl_r[BIT_ON];
    assign inv     = sample_r && con3_r[BIT_INV] && con3_r[BIT_DBL];
    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_com  = reg_wr && (reg_addr == OFS_COM);
    assign start_evt = on && (st_r == CVD_IDLE) &&
                       ((wr_ctrl && reg_wdata[BIT_GO]) || (wr_com && reg_wdata[0]) ||
                        trig_in);
    assign sw_clr  = (wr_ctrl && !reg_wdata[BIT_GO] && go_r) ||
                     (wr_com && !reg_wdata[0] && go_all_r);
    assign abort   = (st_r != CVD_IDLE) && (sw_clr || !on);
    assign seq_end = (st_r == CVD_CONV) && sar_done && !abort &&
                     !(con3_r[BIT_DBL] && !sample_r);

    // Next stage
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CVD_IDLE: if (start_evt) st_nxt = first_stage(pre_r, acq_r);
            CVD_PRE:  if (tmr_exp) st_nxt = (acq_r != 7'h00) ? CVD_ACQ : CVD_CONV;
            CVD_ACQ:  if (tmr_exp) st_nxt = CVD_CONV;
            CVD_CONV: if (sar_done) st_nxt = (con3_r[BIT_DBL] && !sample_r) ? CVD_GAP : CVD_IDLE;
            CVD_GAP:  if (gap_r == GAP_LAST) st_nxt = first_stage(pre_r, acq_r);
            default:  st_nxt = CVD_IDLE;
        endcase
        if (abort)
            st_nxt = CVD_IDLE;
    end

    // Stage register, sample index and gap count
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r     <= CVD_IDLE;
            sample_r <= 1'b0;
            gap_r    <= 2'h0;
        end else begin
            st_r  <= st_nxt;
            gap_r <= (st_r == CVD_GAP) ? gap_r + 2'h1 : 2'h0;
            if (start_evt)
                sample_r <= 1'b0;
            else if (st_r == CVD_CONV && st_nxt == CVD_GAP)
                sample_r <= 1'b1;
        end
    end

    // Go flags held through both samples
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            go_r     <= 1'b0;
            go_all_r <= 1'b0;
        end else if (!on || seq_end || abort) begin
            go_r     <= 1'b0;
            go_all_r <= 1'b0;
        end else if (start_evt) begin
            go_r     <= 1'b1;
            go_all_r <= wr_com && reg_wdata[0];
        end
    end

    // Stage timer loaded on entry to precharge or acquisition
    assign tmr_load = (st_nxt != st_r) && (st_nxt == CVD_PRE || st_nxt == CVD_ACQ);

    cvd_stage_timer u_timer (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .load     (tmr_load),
        .load_val ((st_nxt == CVD_PRE) ? pre_r : acq_r),
        .tick     (cycle_tick),
        .expire   (tmr_exp)
    );

    cvd_sar u_sar (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .start     (st_nxt == CVD_CONV && st_r != CVD_CONV),
        .abort     (abort && st_r == CVD_CONV),
        .tick      (cycle_tick),
        .cmp_in    (cmp_in),
        .trial     (sar_trial),
        .result    (sar_res),
        .res_valid (sar_valid),
        .done      (sar_done)
    );

    // Control registers written by software
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_r <= REG_RST;
            con3_r <= REG_RST;
            pre_r  <= CNT_RST;
            acq_r  <= CNT_RST;
            grd_r  <= REG_RST;
            cap_r  <= 4'h0;
            ch_r   <= REG_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: ctrl_r <= {1'b0, reg_wdata[6:2], 1'b0, reg_wdata[BIT_ON]};
                OFS_CON3: con3_r <= reg_wdata;
                OFS_PRE:  pre_r  <= reg_wdata[6:0];
                OFS_ACQ:  acq_r  <= reg_wdata[6:0];
                OFS_GRD:  grd_r  <= reg_wdata;
                OFS_CAP:  cap_r  <= reg_wdata[3:0];
                OFS_CH:   ch_r   <= reg_wdata;
                default:  ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Result sets, one per sample
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            res0_r <= RES_RST;
            res1_r <= RES_RST;
        end else if (sar_valid) begin
            if (sample_r)
                res1_r <= sar_res;
            else
                res0_r <= sar_res;
        end
    end

    // Done flag: hardware set wins over software clear
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            flag_r <= 1'b0;
        else
            flag_r <= seq_end ||
                      (flag_r && !(reg_wr && reg_addr == OFS_FLAG && !reg_wdata[0]));
    end

    // Guard level set at precharge, toggled at acquisition
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            guard_lvl_r <= 1'b0;
        else if (st_nxt == CVD_PRE && st_r != CVD_PRE)
            guard_lvl_r <= grd_r[BIT_GPOL] ^ (sample_r && con3_r[BIT_INV] &&
                           con3_r[BIT_DBL] && st_r == CVD_GAP);
        else if (st_nxt == CVD_ACQ && st_r != CVD_ACQ)
            guard_lvl_r <= ~(grd_r[BIT_GPOL] ^ (con3_r[BIT_INV] && con3_r[BIT_DBL] &&
                           (sample_r || st_r == CVD_GAP) && !start_evt));
    end

    // Register read, data valid the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_r <= REG_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: rdata_r <= {1'b0, ctrl_r[6:2], go_r, on};
                OFS_COM:  rdata_r <= {7'h00, go_all_r};
                OFS_CON3: rdata_r <= con3_r;
                OFS_STAT: rdata_r <= {4'h0, sample_r, 3'(st_r)};
                OFS_PRE:  rdata_r <= {1'b0, pre_r};
                OFS_ACQ:  rdata_r <= {1'b0, acq_r};
                OFS_GRD:  rdata_r <= grd_r;
                OFS_CAP:  rdata_r <= {4'h0, cap_r};
                OFS_R0L:  rdata_r <= res0_r[7:0];
                OFS_R0H:  rdata_r <= {6'h00, res0_r[9:8]};
                OFS_R1L:  rdata_r <= res1_r[7:0];
                OFS_R1H:  rdata_r <= {6'h00, res1_r[9:8]};
                OFS_CH:   rdata_r <= ch_r;
                OFS_FLAG: rdata_r <= {7'h00, flag_r};
                default:  rdata_r <= REG_RST;
            endcase
        end
    end

    // Analog and pin controls follow the stage
    assign reg_rdata       = rdata_r;
    assign conv_active     = (st_r == CVD_CONV);
    assign conversion_done_flag = flag_r;
    assign hold_bias_en    = (st_r == CVD_PRE);
    assign hold_bias_high  = con3_r[BIT_IPOL] ^ inv;
    assign pin_drive_en    = (st_r == CVD_PRE);
    assign pin_drive_high  = con3_r[BIT_EPOL] ^ inv;
    assign mux_connect     = on && (st_r != CVD_PRE);
    assign mux_channel     = ctrl_r[6:2];
    assign sec_mux_connect = {8{mux_connect}} & ch_r;
    assign sec_force_input = ch_r;
    assign sec_drive_en    = {8{st_r == CVD_PRE}} & ch_r;
    assign extra_cap_sel   = (st_r == CVD_CONV) ? 4'h0 : cap_r;
    assign guard_a         = guard_lvl_r;
    assign guard_b         = guard_lvl_r;
    assign guard_a_oe      = on && grd_r[BIT_GA];
    assign guard_b_oe      = on && grd_r[BIT_GB];

    // Checks on sequencing and drive
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_first_done;
        st_r == CVD_CONV && sar_done && !abort && con3_r[BIT_DBL] && !sample_r;
    endsequence
    sequence s_gap_pair;
        (st_r == CVD_GAP && go_r)[*2] ##1 (st_r != CVD_GAP);
    endsequence

    a_pre_skip: assert property (start_evt && pre_r == 7'h00 |=> st_r != CVD_PRE)
        else $error("precharge entered with zero count");
    a_pre_drive: assert property (st_r == CVD_PRE |-> pin_drive_en && hold_bias_en &&
        !mux_connect && pin_drive_high == (con3_r[BIT_EPOL] ^ inv))
        else $error("precharge drive wrong");
    a_acq_release: assert property (st_r == CVD_ACQ |-> !pin_drive_en && mux_connect)
        else $error("acquisition did not release pin");
    a_go_held: assert property (st_r != CVD_IDLE && $past(st_r) != CVD_IDLE |-> go_r)
        else $error("go dropped during sequence");
    a_gap_two: assert property (s_first_done |=> s_gap_pair)
        else $error("gap between samples not two cycles");
    a_cap_off: assert property (st_r == CVD_CONV |-> extra_cap_sel == 4'h0)
        else $error("extra capacitance during conversion");
    a_off_mux: assert property (!on |-> !mux_connect && sec_mux_connect == 8'h00)
        else $error("mux connected while disabled");
    a_abort_noflag: assert property (abort && !flag_r |=> !flag_r)
        else $error("done flag set by aborted conversion");
    a_done_clear: assert property (seq_end |=> !go_r && flag_r)
        else $error("completion did not clear go or set flag");
    a_guard_acq: assert property ($rose(st_r == CVD_ACQ) && sample_r == 1'b0 |->
        guard_lvl_r == ~grd_r[BIT_GPOL])
        else $error("guard not toggled at acquisition");
endmodule
`default_nettype wire

// >>> logic/cvd_stage_timer.sv
// Down counter timing the precharge and acquisition stages
// Assumes tick is a one-cycle pulse per instruction or conversion clock period
`timescale 1ns/1ps
`default_nettype none
module cvd_stage_timer
    import cvd_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Load and time base
    input  wire logic       load,
    input  wire logic [6:0] load_val,
    input  wire logic       tick,
    // Stage end
    output logic            expire
);
    logic [6:0] cnt_r;

    // Count down one per tick
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            cnt_r <= CNT_RST;
        else if (load)
            cnt_r <= load_val;
        else if (tick && cnt_r != 7'h00)
            cnt_r <= cnt_r - 7'h01;
    end

    // Last tick of the loaded count
    assign expire = tick && (cnt_r == 7'h01);
endmodule
`default_nettype wire

// >>> verif/cvd_pad_model.sv
// Sensor pad and comparator model facing the sequencer
// Assumes trial words arrive registered on ref_clk
`timescale 1ns/1ps
`default_nettype none
module cvd_pad_model (
    // Clock
    input  wire logic       ref_clk,
    // Pin override
    input  wire logic       pin_drive_en,
    input  wire logic       pin_drive_high,
    // Settled levels and trial word
    input  wire logic [9:0] sar_trial,
    input  wire logic [9:0] vin_hi,
    input  wire logic [9:0] vin_lo,
    output logic            cmp_in
);
    logic pol_r = 1'b0;
    // Remember the level the pad was precharged to
    always @(posedge ref_clk) begin
        if (pin_drive_en) begin
            pol_r <= pin_drive_high;
        end
    end
    // Divider voltage against the trial word
    assign cmp_in = ((pol_r ? vin_hi : vin_lo) >= sar_trial);
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the capacitive divider sequencer
// Assumes the pad model answers the comparator at once
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cvd_pkg::*;
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       cycle_tick = 1'b1;
    logic       trig_in = 1'b0;
    logic [9:0] vin_hi = 10'h000;
    logic [9:0] vin_lo = 10'h000;
    logic [7:0] reg_rdata, sec_mux_connect, sec_force_input, sec_drive_en;
    logic [9:0] sar_trial;
    logic [3:0] extra_cap_sel;
    logic [4:0] mux_channel;
    logic       cmp_in, conv_active, conversion_done_flag, hold_bias_en, hold_bias_high;
    logic       mux_connect, pin_drive_en, pin_drive_high;
    logic       guard_a, guard_a_oe, guard_b, guard_b_oe;
    logic [7:0] exp_q[$];
    logic       rd_pend = 1'b0;
    int         num_errors = 0;
    int         checked = 0;

    // Clock
    always #50 ref_clk = ~ref_clk;

    cvd_seq u_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cycle_tick(cycle_tick), .trig_in(trig_in), .cmp_in(cmp_in), .sar_trial(sar_trial),
        .conv_active(conv_active), .conversion_done_flag(conversion_done_flag),
        .hold_bias_en(hold_bias_en), .hold_bias_high(hold_bias_high),
        .extra_cap_sel(extra_cap_sel), .mux_connect(mux_connect), .mux_channel(mux_channel),
        .sec_mux_connect(sec_mux_connect), .sec_force_input(sec_force_input),
        .pin_drive_en(pin_drive_en), .pin_drive_high(pin_drive_high),
        .sec_drive_en(sec_drive_en), .guard_a(guard_a), .guard_a_oe(guard_a_oe),
        .guard_b(guard_b), .guard_b_oe(guard_b_oe));

    cvd_pad_model u_pad (.ref_clk(ref_clk), .pin_drive_en(pin_drive_en),
        .pin_drive_high(pin_drive_high), .sar_trial(sar_trial), .vin_hi(vin_hi),
        .vin_lo(vin_lo), .cmp_in(cmp_in));

    // Count and report one comparison
    task automatic chk(input bit ok, input string s);
        checked++;
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask

    // Bus cycles; strobes stay up across back-to-back accesses
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
    endtask
    task automatic nop(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask

    // Stage outputs each cycle: pin, mux, conv, guard, extra cap
    task automatic look(input int n, input logic [4:0] f, input logic [4:0] m, input string s);
        repeat (n) begin
            #10;
            chk((({pin_drive_en, mux_connect, conv_active, guard_a,
                   extra_cap_sel != 4'h0} ^ f) & m) === 5'h00, s);
            @(posedge ref_clk);
        end
    endtask

    // Read data stands in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_pend) begin
            chk(reg_rdata === exp_q.pop_front(), "read data");
        end
        rd_pend <= reg_rd;
    end

    task automatic end_of_test;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #4000000;
        num_errors++;
        $display("[FAIL] %0t timeout", $time);
        end_of_test();
    end

    // Main sequence
    initial begin
        void'($urandom(87054));
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_STAT, 8'h00);
        rd(4'hE, 8'h00);
        wr(OFS_CTRL, 8'h02);
        nop(1);
        rd(OFS_STAT, 8'h00);
        // Single sample with both timed stages
        wr(OFS_CTRL, 8'h0D);
        wr(OFS_PRE, 8'h02);
        wr(OFS_ACQ, 8'h03);
        wr(OFS_GRD, 8'hC1);
        wr(OFS_CAP, 8'h05);
        wr(OFS_CH, 8'h81);
        wr(OFS_CON3, 8'h01);
        vin_hi <= 10'($urandom);
        wr(OFS_CTRL, 8'h0F);
        nop(0);
        #10;
        chk({pin_drive_high, hold_bias_en, hold_bias_high, guard_a_oe, guard_b_oe} === 5'h1B,
            "precharge drive");
        chk({sec_drive_en, sec_force_input, mux_channel} === 21'h103023, "secondary");
        chk(guard_b === 1'b1, "guard b level");
        look(2, 5'h13, 5'h1F, "precharge");
        look(3, 5'h09, 5'h1F, "acquisition");
        look(11, 5'h0C, 5'h1F, "conversion");
        #10;
        chk(conversion_done_flag === 1'b1, "done flag");
        rd(OFS_R0L, vin_hi[7:0]);
        rd(OFS_R0H, {6'h00, vin_hi[9:8]});
        rd(OFS_CTRL, 8'h0D);
        rd(OFS_FLAG, 8'h01);
        wr(OFS_FLAG, 8'h00);
        rd(OFS_FLAG, 8'h00);
        // Double inverted sample from the trigger
        vin_hi <= 10'($urandom);
        vin_lo <= 10'($urandom);
        wr(OFS_PRE, 8'h01);
        wr(OFS_ACQ, 8'h01);
        wr(OFS_CON3, 8'hC1);
        nop(1);
        trig_in <= 1'b1;
        @(posedge ref_clk);
        trig_in <= 1'b0;
        #10;
        chk({pin_drive_high, hold_bias_high} === 2'b10, "first polarity");
        look(1, 5'h13, 5'h1F, "first precharge");
        look(1, 5'h09, 5'h1F, "first acquisition");
        look(11, 5'h0C, 5'h1F, "first conversion");
        look(2, 5'h08, 5'h1C, "gap");
        #10;
        chk({pin_drive_high, hold_bias_high} === 2'b01, "second polarity");
        look(1, 5'h11, 5'h1F, "second precharge");
        look(1, 5'h0B, 5'h1F, "second acquisition");
        look(11, 5'h0E, 5'h1F, "second conversion");
        rd(OFS_R0L, vin_hi[7:0]);
        rd(OFS_R0H, {6'h00, vin_hi[9:8]});
        rd(OFS_R1L, vin_lo[7:0]);
        rd(OFS_R1H, {6'h00, vin_lo[9:8]});
        rd(OFS_CON3, 8'hC1);
        rd(OFS_CTRL, 8'h0D);
        // All-units start straight into conversion, then abort
        vin_hi <= 10'h3C0;
        vin_lo <= 10'h3C0;
        wr(OFS_PRE, 8'h00);
        wr(OFS_ACQ, 8'h00);
        wr(OFS_CON3, 8'h00);
        wr(OFS_FLAG, 8'h00);
        wr(OFS_COM, 8'h01);
        nop(0);
        look(1, 5'h0C, 5'h1D, "direct conversion");
        rd(OFS_CTRL, 8'h0F);
        wr(OFS_COM, 8'h00);
        nop(3);
        rd(OFS_FLAG, 8'h00);
        rd(OFS_R0L, 8'hFF);
        rd(OFS_R0H, 8'h03);
        rd(OFS_STAT, 8'h00);
        // Converter off releases mux and guards
        wr(OFS_CTRL, 8'h00);
        nop(1);
        #10;
        chk({mux_connect, guard_a_oe, guard_b_oe, sec_mux_connect} === 11'h000,
            "converter off");
        end_of_test();
    end
endmodule
`default_nettype wire
